// File: src/bfc_unit.sv
// Branch, call, return, skip and compare sequencer of the 8-bit core
// Function
// - Pointer jump loads Z, two cycles
// - Offset call pushes, jumps PC+k+1, three cycles
// - Pointer call pushes, loads Z, three cycles
// - Return pops PC from stack, four cycles
// - Equal compare skips next instruction when equal
// - Compares subtract, set flags, one cycle
// - Register bit test skips on clear/set
// - I/O bit test skips on clear/set
// - Generic flag branches test selected status bit
// - Equal/unequal branches follow zero flag
// - Carry branches follow carry flag
// - Minus/plus branches follow negative flag
// - Signed branches follow negative xor overflow
// - Half-carry branches follow half-carry flag
// - Transfer-bit branch taken when T set
`timescale 1ns/1ns
module bfc_unit
#(
  parameter int unsigned PC_W = 16, // Program counter width
  parameter int unsigned OFS_W = 12 // Signed offset width
)
(
  input wire logic clk_i, // Core clock
  input wire logic rst_b_i, // Asynchronous reset, active low
  input wire logic start_i, // Instruction request
  output logic ready_o, // Request can be taken
  input wire bfc_pkg::bfc_op_e op_i, // Operation
  input wire logic [PC_W-1:0] pc_i, // Address of this instruction
  input wire logic [15:0] z_ptr_i, // Z pointer pair
  input wire logic [7:0] rd_i, // First operand register
  input wire logic [7:0] rr_i, // Second operand register
  input wire logic [7:0] imm_i, // Immediate operand
  input wire logic [OFS_W-1:0] offset_i, // Signed relative offset
  input wire logic [2:0] bit_sel_i, // Selected bit
  input wire logic [7:0] io_reg_i, // Addressed I/O register value
  input wire logic next_two_word_i, // Following instruction is two words
  input wire logic [7:0] flags_i, // Current status flags
  input wire logic [PC_W-1:0] stack_data_i, // Popped return address
  output logic done_o, // Last cycle of the instruction
  output logic busy_o, // Instruction in progress
  output logic [PC_W-1:0] pc_o, // Next program counter
  output logic push_o, // Push return address
  output logic [PC_W-1:0] push_data_o, // Return address to push
  output logic pop_o, // Pop return address
  output logic [7:0] flags_o, // New status flags
  output logic flags_we_o // Write new flags
);
  import bfc_pkg::*;

  // Flag condition of a branch operation
  function automatic logic branch_hit(input bfc_op_e op, input logic [7:0] f, input logic [2:0] s);
    case (op)
      BFC_OP_FLAG_SET_BRANCH: branch_hit = f[s];
      BFC_OP_FLAG_CLEAR_BRANCH: branch_hit = !f[s];
      BFC_OP_EQUAL_BRANCH: branch_hit = f[FLAG_Z];
      BFC_OP_UNEQUAL_BRANCH: branch_hit = !f[FLAG_Z];
      BFC_OP_CARRY_SET_BRANCH, BFC_OP_LOWER_BRANCH: branch_hit = f[FLAG_C];
      BFC_OP_CARRY_CLEAR_BRANCH, BFC_OP_SAME_HIGHER_BRANCH: branch_hit = !f[FLAG_C];
      BFC_OP_MINUS_BRANCH: branch_hit = f[FLAG_N];
      BFC_OP_PLUS_BRANCH: branch_hit = !f[FLAG_N];
      BFC_OP_SIGNED_GE_BRANCH: branch_hit = !(f[FLAG_N] ^ f[FLAG_V]);
      BFC_OP_SIGNED_LT_BRANCH: branch_hit = f[FLAG_N] ^ f[FLAG_V];
      BFC_OP_HALFCARRY_SET_BRANCH: branch_hit = f[FLAG_H];
      BFC_OP_HALFCARRY_CLEAR_BRANCH: branch_hit = !f[FLAG_H];
      BFC_OP_TRANSFER_BIT_BRANCH: branch_hit = f[FLAG_T];
      default: branch_hit = 1'b0;
    endcase
  endfunction
  // Operation is a conditional relative branch
  function automatic logic is_branch(input bfc_op_e op);
    is_branch = (op >= BFC_OP_FLAG_SET_BRANCH) && (op <= BFC_OP_TRANSFER_BIT_BRANCH);
  endfunction
  // Operation is one of the three compares
  function automatic logic is_compare(input bfc_op_e op);
    is_compare = (op == BFC_OP_REGISTER_COMPARE) || (op == BFC_OP_CARRY_COMPARE)
      || (op == BFC_OP_IMMEDIATE_COMPARE);
  endfunction
  bfc_state_e state_q; // Sequencer state
  logic [2:0] cnt_q; // Cycles left including this one
  logic last; // Final cycle of a busy instruction
  logic accept; // Request taken this edge
  logic [PC_W-1:0] pc_q; // Target program counter
  logic [PC_W-1:0] pc_next; // Target computed at accept
  logic [PC_W-1:0] pc_plus1; // Address after this instruction
  logic [PC_W-1:0] ofs_ext; // Sign-extended offset
  logic [2:0] cyc_next; // Cycle count computed at accept
  logic skip_hit; // Skip condition met
  logic push_q; // Push pulse
  logic [PC_W-1:0] push_data_q; // Return address held
  logic pop_q; // Pop pulse
  logic popped_q; // Stack data valid this cycle
  logic [7:0] flags_q; // Flags from last compare
  logic flags_we_q; // Flag write pulse
  logic [7:0] sub_b; // Subtrahend
  logic sub_cin; // Borrow in for carry compare
  logic [8:0] diff; // Compare difference with borrow
  logic [7:0] cmp_flags; // Flags from the compare
  // Handshake
  assign last = (state_q == BFC_BUSY) && (cnt_q == CYC_SINGLE);
  assign ready_o = (state_q == BFC_IDLE) || last;
  assign accept = start_i && ready_o;
  assign done_o = last;
  assign busy_o = (state_q == BFC_BUSY);
  assign pc_o = pc_q;
  assign push_o = push_q;
  assign push_data_o = push_data_q;
  assign pop_o = pop_q;
  assign flags_o = flags_q;
  assign flags_we_o = flags_we_q;
  // Common address arithmetic
  assign pc_plus1 = pc_i + PC_W'(STEP_NEXT);
  assign ofs_ext = {{(PC_W-OFS_W){offset_i[OFS_W-1]}}, offset_i};
  // Compare subtraction, result discarded
  always_comb
  begin
    sub_b = (op_i == BFC_OP_IMMEDIATE_COMPARE) ? imm_i : rr_i;
    sub_cin = (op_i == BFC_OP_CARRY_COMPARE) ? flags_i[FLAG_C] : 1'b0;
    diff = {1'b0, rd_i} - {1'b0, sub_b} - {8'h00, sub_cin};
    cmp_flags = flags_i;
    cmp_flags[FLAG_C] = diff[8];
    cmp_flags[FLAG_N] = diff[7];
    cmp_flags[FLAG_V] = (rd_i[7] & ~sub_b[7] & ~diff[7]) | (~rd_i[7] & sub_b[7] & diff[7]);
    cmp_flags[FLAG_H] = (~rd_i[3] & sub_b[3]) | (sub_b[3] & diff[3]) | (diff[3] & ~rd_i[3]);
    // Carry compare keeps zero only if it was already set
    cmp_flags[FLAG_Z] = (diff[7:0] == 8'h00) && ((op_i != BFC_OP_CARRY_COMPARE) || flags_i[FLAG_Z]);
  end
  // Skip condition per skip form
  always_comb
  begin
    case (op_i)
      BFC_OP_EQUAL_COMPARE_SKIP: skip_hit = (rd_i == rr_i);
      BFC_OP_REG_BIT_CLEAR_SKIP: skip_hit = !rr_i[bit_sel_i];
      BFC_OP_REG_BIT_SET_SKIP: skip_hit = rr_i[bit_sel_i];
      BFC_OP_IO_BIT_CLEAR_SKIP: skip_hit = !io_reg_i[bit_sel_i];
      BFC_OP_IO_BIT_SET_SKIP: skip_hit = io_reg_i[bit_sel_i];
      default: skip_hit = 1'b0;
    endcase
  end
  // Target address and cycle count
  always_comb
  begin
    pc_next = pc_plus1;
    cyc_next = CYC_SINGLE;
    case (op_i)
      BFC_OP_POINTER_JUMP, BFC_OP_POINTER_CALL:
      begin
        pc_next = PC_W'(z_ptr_i);
        cyc_next = (op_i == BFC_OP_POINTER_JUMP) ? CYC_JUMP : CYC_CALL;
      end
      BFC_OP_OFFSET_CALL:
      begin
        pc_next = pc_plus1 + ofs_ext;
        cyc_next = CYC_CALL;
      end
      BFC_OP_SUBROUTINE_RETURN:
      begin
        pc_next = pc_i; // Replaced once the stack answers
        cyc_next = CYC_RETURN;
      end
      default:
        if (skip_hit && next_two_word_i)
        begin
          pc_next = pc_i + PC_W'(STEP_SKIP_TWO);
          cyc_next = CYC_SKIP_TWO;
        end
        else if (skip_hit)
        begin
          pc_next = pc_i + PC_W'(STEP_SKIP_ONE);
          cyc_next = CYC_SKIP_ONE;
        end
        else if (is_branch(op_i) && branch_hit(op_i, flags_i, bit_sel_i))
        begin
          pc_next = pc_plus1 + ofs_ext;
          cyc_next = CYC_TAKEN;
        end
    endcase
  end

  // Sequencer state and cycle counter
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= BFC_IDLE;
      cnt_q <= CNT_RESET;
    end
    else if (accept)
    begin
      state_q <= BFC_BUSY;
      cnt_q <= cyc_next;
    end
    else if (last)
    begin
      state_q <= BFC_IDLE;
      cnt_q <= CNT_RESET;
    end
    else if (state_q == BFC_BUSY)
      cnt_q <= cnt_q - 3'h1;
  end

  // Program counter result, return takes popped value
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      pc_q <= '0;
    else if (accept)
      pc_q <= pc_next;
    else if (popped_q)
      pc_q <= stack_data_i;
  end

  // Stack push and pop pulses
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      push_q <= 1'b0;
      push_data_q <= '0;
      pop_q <= 1'b0;
      popped_q <= 1'b0;
    end
    else
    begin
      push_q <= accept && ((op_i == BFC_OP_OFFSET_CALL) || (op_i == BFC_OP_POINTER_CALL));
      pop_q <= accept && (op_i == BFC_OP_SUBROUTINE_RETURN);
      popped_q <= pop_q;
      if (accept)
        push_data_q <= pc_plus1;
    end
  end

  // Flag result, written by compares only
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      flags_q <= FLAGS_RESET;
      flags_we_q <= 1'b0;
    end
    else
    begin
      flags_we_q <= accept && is_compare(op_i);
      if (accept && is_compare(op_i))
        flags_q <= cmp_flags;
    end
  end

  // Two-cycle completion
  sequence s_two_cycle;
    !done_o ##1 done_o;
  endsequence
  // Three-cycle completion
  sequence s_three_cycle;
    !done_o [*2] ##1 done_o;
  endsequence

  a_jump_to_z: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && op_i == BFC_OP_POINTER_JUMP |=> s_two_cycle ##0 pc_o == PC_W'($past(z_ptr_i, 2)))
    else $error("pointer jump target or timing wrong");
  a_offset_call_push: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && op_i == BFC_OP_OFFSET_CALL |=> push_o && push_data_o == $past(pc_i) + PC_W'(1) ##0 s_three_cycle)
    else $error("offset call push or timing wrong");
  a_pointer_call_z: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && op_i == BFC_OP_POINTER_CALL |=> push_o ##0 s_three_cycle ##0 pc_o == PC_W'($past(z_ptr_i, 3)))
    else $error("pointer call target or timing wrong");
  a_return_pops: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && op_i == BFC_OP_SUBROUTINE_RETURN |=> pop_o && !done_o ##3 done_o && pc_o == $past(stack_data_i, 2))
    else $error("return did not restore popped address in four cycles");
  a_equal_skip_one: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && op_i == BFC_OP_EQUAL_COMPARE_SKIP && rd_i == rr_i && !next_two_word_i
    |=> s_two_cycle ##0 pc_o == $past(pc_i, 2) + PC_W'(2))
    else $error("equal skip over one word wrong");
  a_skip_two_word: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && op_i == BFC_OP_REG_BIT_SET_SKIP && rr_i[bit_sel_i] && next_two_word_i
    |=> s_three_cycle ##0 pc_o == $past(pc_i, 3) + PC_W'(3))
    else $error("skip over two words wrong");
  a_compare_zero: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && op_i == BFC_OP_REGISTER_COMPARE
    |=> done_o && flags_we_o && flags_o[FLAG_Z] == ($past(rd_i) == $past(rr_i))
      && flags_o[FLAG_C] == ($past(rd_i) < $past(rr_i)))
    else $error("compare flags or timing wrong");
  a_branch_untaken: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && is_branch(op_i) && !branch_hit(op_i, flags_i, bit_sel_i)
    |=> done_o && !flags_we_o && pc_o == $past(pc_i) + PC_W'(1))
    else $error("untaken branch not one cycle to next address");
  a_equal_branch_taken: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && op_i == BFC_OP_EQUAL_BRANCH && flags_i[FLAG_Z]
    |=> s_two_cycle ##0 pc_o == $past(pc_i, 2) + PC_W'(1) + $past(ofs_ext, 2))
    else $error("taken equal branch wrong");
  a_io_skip_clear: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    accept && op_i == BFC_OP_IO_BIT_CLEAR_SKIP && io_reg_i[bit_sel_i] |=> done_o && pc_o == $past(pc_i) + PC_W'(1))
    else $error("io skip taken on set bit");
endmodule

// File: include/bfc_pkg.sv
// Shared constants and types for the branch and program-flow unit
package bfc_pkg;

  // Operations handled by the unit
  typedef enum logic [4:0] {
    BFC_OP_POINTER_JUMP = 5'h00,
    BFC_OP_OFFSET_CALL = 5'h01,
    BFC_OP_POINTER_CALL = 5'h02,
    BFC_OP_SUBROUTINE_RETURN = 5'h03,
    BFC_OP_EQUAL_COMPARE_SKIP = 5'h04,
    BFC_OP_REGISTER_COMPARE = 5'h05,
    BFC_OP_CARRY_COMPARE = 5'h06,
    BFC_OP_IMMEDIATE_COMPARE = 5'h07,
    BFC_OP_REG_BIT_CLEAR_SKIP = 5'h08,
    BFC_OP_REG_BIT_SET_SKIP = 5'h09,
    BFC_OP_IO_BIT_CLEAR_SKIP = 5'h0A,
    BFC_OP_IO_BIT_SET_SKIP = 5'h0B,
    BFC_OP_FLAG_SET_BRANCH = 5'h0C,
    BFC_OP_FLAG_CLEAR_BRANCH = 5'h0D,
    BFC_OP_EQUAL_BRANCH = 5'h0E,
    BFC_OP_UNEQUAL_BRANCH = 5'h0F,
    BFC_OP_CARRY_SET_BRANCH = 5'h10,
    BFC_OP_CARRY_CLEAR_BRANCH = 5'h11,
    BFC_OP_SAME_HIGHER_BRANCH = 5'h12,
    BFC_OP_LOWER_BRANCH = 5'h13,
    BFC_OP_MINUS_BRANCH = 5'h14,
    BFC_OP_PLUS_BRANCH = 5'h15,
    BFC_OP_SIGNED_GE_BRANCH = 5'h16,
    BFC_OP_SIGNED_LT_BRANCH = 5'h17,
    BFC_OP_HALFCARRY_SET_BRANCH = 5'h18,
    BFC_OP_HALFCARRY_CLEAR_BRANCH = 5'h19,
    BFC_OP_TRANSFER_BIT_BRANCH = 5'h1A
  } bfc_op_e;

  // Sequencer states, Gray along idle to busy
  typedef enum logic [0:0] {
    BFC_IDLE = 1'b0,
    BFC_BUSY = 1'b1
  } bfc_state_e;

  // Bit positions in the status flags register
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_T = 6;

  // Cycle counts per instruction class
  localparam logic [2:0] CYC_JUMP = 3'h2;
  localparam logic [2:0] CYC_CALL = 3'h3;
  localparam logic [2:0] CYC_RETURN = 3'h4;
  localparam logic [2:0] CYC_SINGLE = 3'h1;
  localparam logic [2:0] CYC_TAKEN = 3'h2;
  localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
  localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

  // Program counter advances
  localparam logic [1:0] STEP_NEXT = 2'h1;
  localparam logic [1:0] STEP_SKIP_ONE = 2'h2;
  localparam logic [1:0] STEP_SKIP_TWO = 2'h3;

  // Values after reset
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [2:0] CNT_RESET = 3'h0;

endpackage

// File: verif/tb_top.sv
// Self-checking bench for the branch and program-flow unit
`timescale 1ns/1ns
module tb_top;
  import bfc_pkg::*;
  // Expected outcome of one instruction
  typedef struct {
    logic [15:0] pc; logic chk_pc; int n; logic push; logic [15:0] pushd; logic pop; logic we; logic [7:0] flags;
  } bfc_exp_s;
  logic clk_i, rst_b_i, start_i, next_two_word_i; // Clock, reset, request, skip width
  bfc_op_e op_i; // Operation
  logic [15:0] pc_i, z_ptr_i, stack_data_i; // Addresses
  logic [7:0] rd_i, rr_i, imm_i, io_reg_i, flags_i; // Operands
  logic [11:0] offset_i; // Relative offset
  logic [2:0] bit_sel_i; // Bit select
  logic ready_o, done_o, busy_o, push_o, pop_o, flags_we_o; // Strobes
  logic [15:0] pc_o, push_data_o; // Address results
  logic [7:0] flags_o; // Compare flags
  bfc_exp_s exp_q[$]; // Notes from the driver
  int err_total = 0, comparisons = 0, cycles = 0, cnt = 0, push_n = 0, pop_n = 0, we_n = 0; // Counters
  logic [15:0] seen_pushd; // Return address seen
  logic [7:0] seen_flags; // Flags seen
  integer seed = 32'hA2309F5A; // Random seed
  bfc_unit i_bfc_unit (.clk_i(clk_i), .rst_b_i(rst_b_i), .start_i(start_i), .ready_o(ready_o), .op_i(op_i),
    .pc_i(pc_i), .z_ptr_i(z_ptr_i), .rd_i(rd_i), .rr_i(rr_i), .imm_i(imm_i), .offset_i(offset_i),
    .bit_sel_i(bit_sel_i), .io_reg_i(io_reg_i), .next_two_word_i(next_two_word_i), .flags_i(flags_i),
    .stack_data_i(stack_data_i), .done_o(done_o), .busy_o(busy_o), .pc_o(pc_o), .push_o(push_o),
    .push_data_o(push_data_o), .pop_o(pop_o), .flags_o(flags_o), .flags_we_o(flags_we_o));
  // Clock at 100 ns period
  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Compare one value and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // Whether a skip or branch condition holds
  function automatic logic cond(input bfc_op_e op);
    case (op)
      BFC_OP_EQUAL_COMPARE_SKIP: return rd_i == rr_i;
      BFC_OP_REG_BIT_CLEAR_SKIP: return !rr_i[bit_sel_i];
      BFC_OP_REG_BIT_SET_SKIP: return rr_i[bit_sel_i];
      BFC_OP_IO_BIT_CLEAR_SKIP: return !io_reg_i[bit_sel_i];
      BFC_OP_IO_BIT_SET_SKIP: return io_reg_i[bit_sel_i];
      BFC_OP_FLAG_SET_BRANCH: return flags_i[bit_sel_i];
      BFC_OP_FLAG_CLEAR_BRANCH: return !flags_i[bit_sel_i];
      BFC_OP_EQUAL_BRANCH: return flags_i[FLAG_Z];
      BFC_OP_UNEQUAL_BRANCH: return !flags_i[FLAG_Z];
      BFC_OP_CARRY_SET_BRANCH, BFC_OP_LOWER_BRANCH: return flags_i[FLAG_C];
      BFC_OP_CARRY_CLEAR_BRANCH, BFC_OP_SAME_HIGHER_BRANCH: return !flags_i[FLAG_C];
      BFC_OP_MINUS_BRANCH: return flags_i[FLAG_N];
      BFC_OP_PLUS_BRANCH: return !flags_i[FLAG_N];
      BFC_OP_SIGNED_GE_BRANCH: return !(flags_i[FLAG_N] ^ flags_i[FLAG_V]);
      BFC_OP_SIGNED_LT_BRANCH: return flags_i[FLAG_N] ^ flags_i[FLAG_V];
      BFC_OP_HALFCARRY_SET_BRANCH: return flags_i[FLAG_H];
      BFC_OP_HALFCARRY_CLEAR_BRANCH: return !flags_i[FLAG_H];
      BFC_OP_TRANSFER_BIT_BRANCH: return flags_i[FLAG_T];
      default: return 1'b0;
    endcase
  endfunction
  // Drive one random instruction, note its outcome, hold until accepted
  task automatic issue(input bfc_op_e op);
    bfc_exp_s e;
    logic signed [15:0] k;
    logic [8:0] d;
    logic [4:0] h;
    logic [7:0] sub;
    logic cin;
    op_i = op;
    pc_i = 16'($random(seed));
    z_ptr_i = 16'($random(seed));
    // Popped address must hold through busy cycle 2 of a return
    if (op == BFC_OP_SUBROUTINE_RETURN)
      stack_data_i = 16'($random(seed));
    rd_i = 8'($random(seed));
    rr_i = ($random(seed) & 1) ? rd_i : 8'($random(seed));
    imm_i = ($random(seed) & 1) ? rd_i : 8'($random(seed));
    offset_i = 12'($random(seed));
    bit_sel_i = 3'($random(seed));
    io_reg_i = 8'($random(seed));
    next_two_word_i = 1'($random(seed));
    flags_i = 8'($random(seed));
    start_i = 1'b1;
    k = 16'($signed(offset_i));
    e = '{pc: pc_i + 16'h1, chk_pc: 1'b1, n: 1, push: 1'b0, pushd: pc_i + 16'h1, pop: 1'b0, we: 1'b0, flags: 8'h00};
    case (op)
      BFC_OP_POINTER_JUMP:
      begin
        e.pc = z_ptr_i;
        e.n = 2;
      end
      BFC_OP_OFFSET_CALL:
      begin
        e.pc = pc_i + 16'h1 + k;
        e.n = 3;
        e.push = 1'b1;
      end
      BFC_OP_POINTER_CALL:
      begin
        e.pc = z_ptr_i;
        e.n = 3;
        e.push = 1'b1;
      end
      BFC_OP_SUBROUTINE_RETURN:
      begin
        e.pc = stack_data_i;
        e.n = 4;
        e.pop = 1'b1;
      end
      BFC_OP_REGISTER_COMPARE, BFC_OP_CARRY_COMPARE, BFC_OP_IMMEDIATE_COMPARE:
      begin
        cin = (op == BFC_OP_CARRY_COMPARE) & flags_i[FLAG_C];
        sub = (op == BFC_OP_IMMEDIATE_COMPARE) ? imm_i : rr_i;
        d = {1'b0, rd_i} - {1'b0, sub} - 9'(cin);
        h = {1'b0, rd_i[3:0]} - {1'b0, sub[3:0]} - 5'(cin);
        e.chk_pc = 1'b0;
        e.we = 1'b1;
        e.flags = flags_i;
        e.flags[FLAG_C] = d[8];
        e.flags[FLAG_Z] = (d[7:0] == 8'h00) && (op != BFC_OP_CARRY_COMPARE || flags_i[FLAG_Z]);
        e.flags[FLAG_N] = d[7];
        e.flags[FLAG_V] = (rd_i[7] != sub[7]) && (d[7] != rd_i[7]);
        e.flags[FLAG_H] = h[4];
      end
      default:
        if (cond(op) && op inside {[BFC_OP_EQUAL_COMPARE_SKIP:BFC_OP_IO_BIT_SET_SKIP]})
        begin
          e.pc = pc_i + (next_two_word_i ? 16'h3 : 16'h2);
          e.n = next_two_word_i ? 3 : 2;
        end
        else if (cond(op))
        begin
          e.pc = pc_i + 16'h1 + k;
          e.n = 2;
        end
    endcase
    while (ready_o !== 1'b1)
      @(negedge clk_i);
    exp_q.push_back(e);
    @(negedge clk_i);
  endtask
  // Watch the outputs mid-cycle and compare against the oldest note
  always @(negedge clk_i)
  begin : monitor
    bfc_exp_s e;
    if (rst_b_i === 1'b1 && busy_o === 1'b1)
    begin
      cnt++;
      if (push_o === 1'b1)
      begin
        push_n++;
        seen_pushd = push_data_o;
      end
      if (pop_o === 1'b1)
        pop_n++;
      if (flags_we_o === 1'b1)
      begin
        we_n++;
        seen_flags = flags_o;
      end
      if (done_o === 1'b1)
      begin
        if (exp_q.size() == 0)
          check(32'h1, 32'h0, "done without request");
        else
        begin
          e = exp_q.pop_front();
          check(cnt, e.n, "cycle count");
          if (e.chk_pc)
            check(32'(pc_o), 32'(e.pc), "next pc");
          check(push_n, 32'(e.push), "push pulses");
          if (e.push)
            check(32'(seen_pushd), 32'(e.pushd), "return address");
          check(pop_n, 32'(e.pop), "pop pulses");
          check(we_n, 32'(e.we), "flag writes");
          if (e.we)
            check(32'(seen_flags), 32'(e.flags), "compare flags");
        end
        cnt = 0;
        push_n = 0;
        pop_n = 0;
        we_n = 0;
      end
    end
  end
  // Hang guard
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 12000)
    begin
      err_total++;
      $display("BAD t=%0t run too long", $time);
      finish_test();
    end
  end
  // Outputs expected while reset is held
  task automatic check_reset();
    check({26'h0, ready_o, done_o, busy_o, push_o, pop_o, flags_we_o}, 32'h20, "strobes in reset");
    check({pc_o, push_data_o}, 32'h0, "addresses in reset");
    check({24'h0, flags_o}, 32'h0, "flags in reset");
  endtask
  // Main sequence
  initial
  begin
    rst_b_i = 1'b0;
    start_i = 1'b0;
    op_i = BFC_OP_POINTER_JUMP;
    pc_i = 16'h0000;
    z_ptr_i = 16'h0000;
    stack_data_i = 16'h0000;
    rd_i = 8'h00;
    rr_i = 8'h00;
    imm_i = 8'h00;
    offset_i = 12'h000;
    bit_sel_i = 3'h0;
    io_reg_i = 8'h00;
    next_two_word_i = 1'b0;
    flags_i = 8'h00;
    repeat (4) @(negedge clk_i);
    check_reset();
    rst_b_i = 1'b1;
    $display("test reset values done");
    // Every operation, back to back, random operands
    for (int r = 0; r < 24; r++)
      for (int o = 0; o <= 26; o++)
        issue(bfc_op_e'(o));
    start_i = 1'b0;
    repeat (6) @(negedge clk_i);
    $display("test all operations done");
    // Reset in the middle of a return, then resume
    issue(BFC_OP_SUBROUTINE_RETURN);
    start_i = 1'b0;
    rst_b_i = 1'b0;
    @(negedge clk_i);
    check_reset();
    exp_q.delete();
    cnt = 0;
    push_n = 0;
    pop_n = 0;
    we_n = 0;
    @(negedge clk_i);
    rst_b_i = 1'b1;
    issue(BFC_OP_OFFSET_CALL);
    issue(BFC_OP_EQUAL_BRANCH);
    start_i = 1'b0;
    repeat (6) @(negedge clk_i);
    check(exp_q.size(), 32'h0, "notes left over");
    $display("test reset in mid-run done");
    finish_test();
  end
endmodule
